// ---- core/rfm_defs.vh ----
// constants shared by the reduced-to-full mii bridge and its fifo
`ifndef RFM_DEFS_VH
`define RFM_DEFS_VH

// ----------------------------------------------------------------------------
// widths and fifo depth
// ----------------------------------------------------------------------------
`define RFM_NIB_W        4
`define RFM_BYTE_W       8
`define RFM_WORD_W       10
`define RFM_FIFO_DEPTH   4

// ----------------------------------------------------------------------------
// field positions of a receive fifo word {err, valid, byte}
// ----------------------------------------------------------------------------
`define RFM_WD_BYTE_HI   7
`define RFM_WD_BYTE_LO   0
`define RFM_WD_DV        8
`define RFM_WD_ER        9

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RFM_NIB_RST      4'h0
`define RFM_BYTE_RST     8'h00
`define RFM_SYNC_RST     2'h0

// ----------------------------------------------------------------------------
// timing: link rate, system rate, receive clock loss window
// ----------------------------------------------------------------------------
`define RFM_LINK_MHZ     125
`define RFM_SYS_MHZ      50
`define RFM_LOSS_NS      1000

`endif

// ---- core/rfm_fifo.v ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none

module rfm_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             resetn,
  // filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // ----------------------------------------------------------------------------
  // pointers and fill count
  // ----------------------------------------------------------------------------
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // storage needs no reset; out_valid guards every read
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

endmodule // rfm_fifo

`default_nettype wire

// ---- core/rfm_bridge.v ----
// reduced-to-full mii bridge: gmii byte stream to and from rgmii ddr nibbles
`timescale 1ns/1ns
`default_nettype none
`include "rfm_defs.vh"

module rfm_reduced_to_full_mii_bridge #(
  parameter NIB_W         = `RFM_NIB_W,
  parameter BYTE_W        = `RFM_BYTE_W,
  parameter FIFO_DEPTH    = `RFM_FIFO_DEPTH,
  parameter RX_CLK_REGION = 1'b0
) (
  // system clock and reset
  input  wire              clk_sys,
  input  wire              resetn,
  // gmii transmit side, timed by the fabric transmit clock
  input  wire              gmii_tx_clk,
  input  wire [BYTE_W-1:0] gmii_txd,
  input  wire              gmii_tx_en,
  input  wire              gmii_tx_er,
  // rgmii transmit pins toward the phy
  output wire [NIB_W-1:0]  rgmii_txd,
  output wire              rgmii_tx_ctl,
  // rgmii receive pins from the phy
  input  wire              rgmii_rx_clk,
  input  wire [NIB_W-1:0]  rgmii_rxd,
  input  wire              rgmii_rx_ctl,
  // gmii receive side toward the mac
  output wire              gmii_rx_clk,
  output wire              gmii_rx_clk_regional,
  output wire [BYTE_W-1:0] gmii_rxd,
  output wire              gmii_rx_dv,
  output wire              gmii_rx_er,
  output wire              gmii_rx_stb,
  input  wire              gmii_rx_ready,
  output wire              gmii_col,
  output wire              gmii_crs,
  // receive buffer and link status
  output wire              rx_in_ready,
  output wire              rx_overflow,
  input  wire              rx_overflow_clr,
  output wire              rx_link_up
);

  // ----------------------------------------------------------------------------
  // timing constants
  // ----------------------------------------------------------------------------
  localparam integer LOSS_CYC = (`RFM_LOSS_NS * `RFM_SYS_MHZ) / 1000;
  localparam integer LOSS_W   = 8;
  localparam [LOSS_W-1:0] LOSS_MAX = LOSS_CYC[LOSS_W-1:0];

  // transmit gearbox phases
  localparam [1:0] TX_IDLE = 2'h0;
  localparam [1:0] TX_LOW  = 2'h1;
  localparam [1:0] TX_HIGH = 2'h2;

  // ----------------------------------------------------------------------------
  // input synchronisers: clocks, transmit byte, receive pins
  // ----------------------------------------------------------------------------
  reg [1:0]        txc_sync_q;
  reg              txc_last_q;
  reg [BYTE_W-1:0] txd_s1_q;
  reg [BYTE_W-1:0] txd_s2_q;
  reg [1:0]        txen_sync_q;
  reg [1:0]        txer_sync_q;
  reg [1:0]        rxc_sync_q;
  reg              rxc_last_q;
  reg [NIB_W-1:0]  rxd_s1_q;
  reg [NIB_W-1:0]  rxd_s2_q;
  reg [1:0]        rxctl_sync_q;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      txc_sync_q   <= `RFM_SYNC_RST;
      txc_last_q   <= 1'b0;
      txd_s1_q     <= `RFM_BYTE_RST;
      txd_s2_q     <= `RFM_BYTE_RST;
      txen_sync_q  <= `RFM_SYNC_RST;
      txer_sync_q  <= `RFM_SYNC_RST;
      rxc_sync_q   <= `RFM_SYNC_RST;
      rxc_last_q   <= 1'b0;
      rxd_s1_q     <= `RFM_NIB_RST;
      rxd_s2_q     <= `RFM_NIB_RST;
      rxctl_sync_q <= `RFM_SYNC_RST;
    end else begin
      txc_sync_q   <= {txc_sync_q[0], gmii_tx_clk};
      txc_last_q   <= txc_sync_q[1];
      txd_s1_q     <= gmii_txd;
      txd_s2_q     <= txd_s1_q;
      txen_sync_q  <= {txen_sync_q[0], gmii_tx_en};
      txer_sync_q  <= {txer_sync_q[0], gmii_tx_er};
      rxc_sync_q   <= {rxc_sync_q[0], rgmii_rx_clk};
      rxc_last_q   <= rxc_sync_q[1];
      rxd_s1_q     <= rgmii_rxd;
      rxd_s2_q     <= rxd_s1_q;
      rxctl_sync_q <= {rxctl_sync_q[0], rgmii_rx_ctl};
    end
  end

  // edges of both link clocks, seen by the system clock
  wire tx_rise = txc_sync_q[1] & ~txc_last_q;
  wire tx_fall = ~txc_sync_q[1] & txc_last_q;
  wire rx_rise = rxc_sync_q[1] & ~rxc_last_q;
  wire rx_fall = ~rxc_sync_q[1] & rxc_last_q;

  // ----------------------------------------------------------------------------
  // transmit ddr output gearbox
  // ----------------------------------------------------------------------------
  // the gmii byte is taken at the falling edge, mid-period, where the fabric
  // holds it stable; this costs one link period of latency
  reg [BYTE_W-1:0] tx_hold_q;
  reg              tx_hold_en_q;
  reg              tx_hold_er_q;
  reg [BYTE_W-1:0] tx_cur_q;
  reg              tx_cur_en_q;
  reg              tx_cur_er_q;
  reg [1:0]        tx_phase_q;
  reg [NIB_W-1:0]  txd_q;
  reg              tx_ctl_q;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_hold_q    <= `RFM_BYTE_RST;
      tx_hold_en_q <= 1'b0;
      tx_hold_er_q <= 1'b0;
      tx_cur_q     <= `RFM_BYTE_RST;
      tx_cur_en_q  <= 1'b0;
      tx_cur_er_q  <= 1'b0;
      tx_phase_q   <= TX_IDLE;
      txd_q        <= `RFM_NIB_RST;
      tx_ctl_q     <= 1'b0;
    end else begin
      case (tx_phase_q)
        TX_IDLE: begin
          if (tx_fall) begin
            tx_hold_q    <= txd_s2_q;
            tx_hold_en_q <= txen_sync_q[1];
            tx_hold_er_q <= txer_sync_q[1];
            tx_phase_q   <= TX_LOW;
          end
        end
        TX_LOW: begin
          if (tx_rise) begin
            tx_cur_q    <= tx_hold_q;
            tx_cur_en_q <= tx_hold_en_q;
            tx_cur_er_q <= tx_hold_er_q;
            txd_q       <= tx_hold_q[NIB_W-1:0];
            tx_ctl_q    <= tx_hold_en_q;
            tx_phase_q  <= TX_HIGH;
          end
        end
        TX_HIGH: begin
          if (tx_fall) begin
            txd_q        <= tx_cur_q[BYTE_W-1:NIB_W];
            tx_ctl_q     <= tx_cur_en_q | tx_cur_er_q;
            tx_hold_q    <= txd_s2_q;
            tx_hold_en_q <= txen_sync_q[1];
            tx_hold_er_q <= txer_sync_q[1];
            tx_phase_q   <= TX_LOW;
          end
        end
        default: begin
          tx_phase_q <= TX_IDLE;
        end
      endcase
    end
  end

  assign rgmii_txd    = txd_q;
  assign rgmii_tx_ctl = tx_ctl_q;

  // ----------------------------------------------------------------------------
  // receive ddr input gearbox
  // ----------------------------------------------------------------------------
  // the phy must present data centred on each edge; the gearbox has no
  // adjustable delay, alignment is fixed by the two-flop sampling
  reg [NIB_W-1:0] rx_low_q;
  reg             rx_dv_half_q;
  reg             rx_have_low_q;
  reg             rx_push_q;
  reg [`RFM_WORD_W-1:0] rx_word_q;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_low_q      <= `RFM_NIB_RST;
      rx_dv_half_q  <= 1'b0;
      rx_have_low_q <= 1'b0;
      rx_push_q     <= 1'b0;
      rx_word_q     <= {`RFM_WORD_W{1'b0}};
    end else begin
      rx_push_q <= 1'b0;
      if (rx_rise) begin
        rx_low_q      <= rxd_s2_q;
        rx_dv_half_q  <= rxctl_sync_q[1];
        rx_have_low_q <= 1'b1;
      end else if (rx_fall && rx_have_low_q) begin
        rx_have_low_q <= 1'b0;
        rx_push_q     <= 1'b1;
        rx_word_q[`RFM_WD_BYTE_HI:`RFM_WD_BYTE_LO] <= {rxd_s2_q, rx_low_q};
        rx_word_q[`RFM_WD_DV] <= rx_dv_half_q;
        rx_word_q[`RFM_WD_ER] <= rx_dv_half_q ^ rxctl_sync_q[1];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // receive buffer and overflow flag
  // ----------------------------------------------------------------------------
  // the phy cannot be stalled, so a byte arriving on a full buffer is dropped
  // and flagged; fifo_in_ready is offered at the port for the system to watch
  wire                   fifo_in_ready;
  wire                   fifo_out_valid;
  wire [`RFM_WORD_W-1:0] fifo_out_data;
  wire                   fifo_pop;
  reg                    overflow_q;

  rfm_fifo #(
    .WIDTH (`RFM_WORD_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (2)
  ) u_rx_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .in_valid  (rx_push_q),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_word_q),
    .out_valid (fifo_out_valid),
    .out_ready (gmii_rx_ready),
    .out_data  (fifo_out_data)
  );

  assign fifo_pop    = fifo_out_valid & gmii_rx_ready;
  assign rx_in_ready = fifo_in_ready;

  // a drop in the clear cycle still sets the flag
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      overflow_q <= 1'b0;
    end else if (rx_push_q && !fifo_in_ready) begin
      overflow_q <= 1'b1;
    end else if (rx_overflow_clr) begin
      overflow_q <= 1'b0;
    end
  end

  assign rx_overflow = overflow_q;

  // ----------------------------------------------------------------------------
  // gmii receive outputs
  // ----------------------------------------------------------------------------
  reg [BYTE_W-1:0] rxd_q;
  reg              rx_dv_q;
  reg              rx_er_q;
  reg              rx_stb_q;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rxd_q    <= `RFM_BYTE_RST;
      rx_dv_q  <= 1'b0;
      rx_er_q  <= 1'b0;
      rx_stb_q <= 1'b0;
    end else begin
      rx_stb_q <= fifo_pop;
      if (fifo_pop) begin
        rxd_q   <= fifo_out_data[`RFM_WD_BYTE_HI:`RFM_WD_BYTE_LO];
        rx_dv_q <= fifo_out_data[`RFM_WD_DV];
        rx_er_q <= fifo_out_data[`RFM_WD_ER];
      end
    end
  end

  assign gmii_rxd    = rxd_q;
  assign gmii_rx_dv  = rx_dv_q;
  assign gmii_rx_er  = rx_er_q;
  assign gmii_rx_stb = rx_stb_q;

  // ----------------------------------------------------------------------------
  // recovered receive clock, carrier sense, collision, link watch
  // ----------------------------------------------------------------------------
  // carrier and collision come straight from the sampled pins, not from the
  // byte stream, so they carry no alignment to either gmii clock
  reg              rx_clk_q;
  reg              crs_q;
  reg              col_q;
  reg [LOSS_W-1:0] loss_cnt_q;
  reg              link_up_q;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_clk_q   <= 1'b0;
      crs_q      <= 1'b0;
      col_q      <= 1'b0;
      loss_cnt_q <= {LOSS_W{1'b0}};
      link_up_q  <= 1'b0;
    end else begin
      rx_clk_q <= rxc_sync_q[1];
      crs_q    <= rxctl_sync_q[1];
      col_q    <= rxctl_sync_q[1] & txen_sync_q[1];
      if (rx_rise || rx_fall) begin
        loss_cnt_q <= {LOSS_W{1'b0}};
        link_up_q  <= 1'b1;
      end else if (loss_cnt_q == LOSS_MAX) begin
        link_up_q <= 1'b0;
      end else begin
        loss_cnt_q <= loss_cnt_q + 1'b1;
      end
    end
  end

  assign gmii_rx_clk          = rx_clk_q;
  assign gmii_rx_clk_regional = RX_CLK_REGION;
  assign gmii_crs             = crs_q;
  assign gmii_col             = col_q;
  assign rx_link_up           = link_up_q;

endmodule // rfm_reduced_to_full_mii_bridge

`default_nettype wire

// ---- verif/rfm_phy_model.sv ----
// behavioural phy driving the receive rgmii pins of the bridge
`timescale 1ns/1ns
`default_nettype none

module rfm_phy_model (
  // receive pins toward the bridge
  output var logic       rx_clk,
  output var logic [3:0] rxd,
  output var logic       rx_ctl
);
  initial begin
    rx_clk = 1'b0;
    rxd    = 4'h5;
    rx_ctl = 1'b0;
  end

  // one byte per 160 ns period; data centred so it is steady at both clock edges
  task automatic send_byte(input logic [7:0] b, input logic dv, input logic er);
    rxd    = b[3:0];
    rx_ctl = dv;
    #40 rx_clk = 1'b1;
    #40 rxd = b[7:4];
    rx_ctl = dv ^ er;
    #40 rx_clk = 1'b0;
    #40;
  endtask

  // clock stands still between frames; undriven data shows the inverse of its last value
  task automatic stop();
    rxd    = ~rxd;
    rx_ctl = 1'b0;
  endtask
endmodule // rfm_phy_model

`default_nettype wire

// ---- verif/rfm_bridge_properties.sv ----
// concurrent checks on the ports of the bridge
`timescale 1ns/1ns
`default_nettype none

module rfm_bridge_properties #(
  parameter RX_CLK_REGION = 1'b0
) (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       resetn,
  // transmit side
  input wire logic       gmii_tx_clk,
  input wire logic       gmii_tx_en,
  input wire logic [3:0] rgmii_txd,
  input wire logic       rgmii_tx_ctl,
  // receive side
  input wire logic       rgmii_rx_clk,
  input wire logic       rgmii_rx_ctl,
  input wire logic       gmii_rx_clk,
  input wire logic       gmii_col,
  input wire logic       gmii_crs,
  input wire logic       gmii_rx_clk_regional,
  input wire logic [7:0] gmii_rxd,
  input wire logic       gmii_rx_stb,
  input wire logic       gmii_rx_ready,
  input wire logic       rx_in_ready,
  input wire logic       rx_overflow,
  input wire logic       rx_overflow_clr,
  input wire logic       rx_link_up
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------------
  // idle counter of the receive clock, saturating to stay small
  // ----------------------------------------------------------------------
  logic       rx_clk_q;
  logic [6:0] idle_q;
  logic [2:0] up_q;
  // up_q keeps the follow checks away from history that predates reset
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_clk_q <= 1'b0;
      idle_q   <= 7'h00;
      up_q     <= 3'h0;
    end else begin
      rx_clk_q <= rgmii_rx_clk;
      if (up_q != 3'h7)
        up_q <= up_q + 3'h1;
      if (rgmii_rx_clk != rx_clk_q)
        idle_q <= 7'h00;
      else if (idle_q != 7'h7f)
        idle_q <= idle_q + 7'h01;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  region_const_a: assert property (gmii_rx_clk_regional == RX_CLK_REGION)
    else $error("receive clock network flag differs from its setting");
  rxd_hold_a: assert property ($changed(gmii_rxd) |-> gmii_rx_stb)
    else $error("receive byte changed without a strobe");
  stb_ready_a: assert property (gmii_rx_stb |-> $past(gmii_rx_ready))
    else $error("strobe without the mac being ready");
  tx_cause_a: assert property ($changed(rgmii_txd) |-> $past(gmii_tx_clk, 2) != $past(gmii_tx_clk, 5))
    else $error("transmit nibble changed without a transmit clock edge");
  txctl_fall_a: assert property ($fell(rgmii_tx_ctl) |-> $past(gmii_tx_clk, 2))
    else $error("transmit control dropped outside a rising half");
  ovf_cause_a: assert property ($rose(rx_overflow) |-> $past(rx_in_ready) == 1'b0)
    else $error("overflow raised while the buffer had room");
  ovf_sticky_a: assert property (rx_overflow && !rx_overflow_clr |=> rx_overflow)
    else $error("overflow cleared without a clear request");
  link_idle_a: assert property (idle_q >= 7'd60 |-> !rx_link_up)
    else $error("link still up after a long idle receive clock");
  rx_clk_follow_a: assert property (up_q == 3'h7 |-> gmii_rx_clk == $past(rgmii_rx_clk, 3))
    else $error("recovered receive clock does not follow the phy clock");
  crs_follow_a: assert property (up_q == 3'h7 |-> gmii_crs == $past(rgmii_rx_ctl, 3))
    else $error("carrier sense does not follow receive control");
  col_follow_a: assert property (up_q == 3'h7 |-> gmii_col == $past(rgmii_rx_ctl & gmii_tx_en, 3))
    else $error("collision does not follow receive control and transmit enable");

  cover property (gmii_rx_stb);
  cover property ($rose(rx_overflow));
  cover property ($fell(rgmii_tx_ctl));
endmodule // rfm_bridge_properties

`default_nettype wire

// ---- verif/test_rfm_bridge.sv ----
// self-checking bench of the reduced-to-full mii bridge
`timescale 1ns/1ns
`default_nettype none

module test_rfm_bridge;
  logic       clk_sys, resetn, gmii_tx_clk, gmii_tx_en, gmii_tx_er, gmii_rx_ready, rx_overflow_clr;
  logic [7:0] gmii_txd;
  wire logic       rgmii_rx_clk, rgmii_rx_ctl, gmii_rx_dv, gmii_rx_er, gmii_rx_stb, rx_in_ready, rx_overflow;
  wire logic       rgmii_tx_ctl, rx_link_up;
  wire logic [3:0] rgmii_txd, rgmii_rxd;
  wire logic [7:0] gmii_rxd;
  logic [9:0] got [$];
  int         error_cnt, compares, cyc;

  rfm_reduced_to_full_mii_bridge #(.RX_CLK_REGION(1'b1)) dut (
    .clk_sys(clk_sys), .resetn(resetn), .gmii_tx_clk(gmii_tx_clk), .gmii_txd(gmii_txd),
    .gmii_tx_en(gmii_tx_en), .gmii_tx_er(gmii_tx_er), .rgmii_txd(rgmii_txd), .rgmii_tx_ctl(rgmii_tx_ctl),
    .rgmii_rx_clk(rgmii_rx_clk), .rgmii_rxd(rgmii_rxd), .rgmii_rx_ctl(rgmii_rx_ctl), .gmii_rx_clk(),
    .gmii_rx_clk_regional(), .gmii_rxd(gmii_rxd), .gmii_rx_dv(gmii_rx_dv), .gmii_rx_er(gmii_rx_er),
    .gmii_rx_stb(gmii_rx_stb), .gmii_rx_ready(gmii_rx_ready), .gmii_col(), .gmii_crs(),
    .rx_in_ready(rx_in_ready), .rx_overflow(rx_overflow), .rx_overflow_clr(rx_overflow_clr),
    .rx_link_up(rx_link_up));
  rfm_phy_model phy (.rx_clk(rgmii_rx_clk), .rxd(rgmii_rxd), .rx_ctl(rgmii_rx_ctl));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // fabric transmit clock runs free, out of phase with the system clock
  initial begin
    gmii_tx_clk = 1'b0;
    #7;
    forever #80 gmii_tx_clk = ~gmii_tx_clk;
  end
  // strobe and byte are taken mid-cycle, away from the edge that launches them
  always @(negedge clk_sys) begin
    if (gmii_rx_stb === 1'b1)
      got.push_back({gmii_rx_er, gmii_rx_dv, gmii_rxd});
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input logic [9:0] got_v, input logic [9:0] exp_v);
    compares++;
    if (got_v !== exp_v) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // each byte set at a rising tx edge is latched at the falling one and leaves one half later
  task automatic tx_burst();
    logic [9:0] tb [0:5];
    tb = '{10'h1a5, 10'h33c, 10'h2f0, 10'h00f, 10'h000, 10'h000};
    for (int k = 0; k < 6; k++) begin
      @(posedge gmii_tx_clk);
      {gmii_tx_er, gmii_tx_en, gmii_txd} = tb[k];
      #20;
      if (k >= 2) chk({5'h0, rgmii_tx_ctl, rgmii_txd}, {5'h0, tb[k-2][9] | tb[k-2][8], tb[k-2][7:4]});
      @(negedge gmii_tx_clk);
      #20;
      if (k >= 1) chk({5'h0, rgmii_tx_ctl, rgmii_txd}, {5'h0, tb[k-1][8], tb[k-1][3:0]});
    end
  endtask

  // every valid/error combination, including error without valid
  task automatic rx_frame();
    logic [9:0] ex [0:3];
    ex = '{10'h155, 10'h3d5, 10'h2a3, 10'h00f};
    got.delete();
    for (int i = 0; i < 4; i++)
      phy.send_byte(ex[i][7:0], ex[i][8], ex[i][9]);
    phy.stop();
    @(negedge clk_sys);
    chk({9'h0, rx_link_up}, 10'h001);
    repeat (20) @(negedge clk_sys);
    chk(10'(got.size()), 10'h004);
    for (int i = 0; i < 4 && i < got.size(); i++)
      chk(got[i], ex[i]);
  endtask

  // mac stalls while six bytes arrive: four are kept, the rest dropped and flagged
  task automatic rx_overflow_run();
    gmii_rx_ready = 1'b0;
    for (int i = 0; i < 6; i++)
      phy.send_byte(8'h10 + 8'(i), 1'b1, 1'b0);
    phy.stop();
    repeat (10) @(negedge clk_sys);
    chk({8'h0, rx_in_ready, rx_overflow}, 10'h001);
    got.delete();
    gmii_rx_ready = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk({8'h0, rx_in_ready, rx_overflow}, 10'h003);
    chk(10'(got.size()), 10'h004);
    for (int i = 0; i < 4 && i < got.size(); i++)
      chk(got[i], 10'h110 + 10'(i));
    rx_overflow_clr = 1'b1;
    @(negedge clk_sys);
    rx_overflow_clr = 1'b0;
    @(negedge clk_sys);
    chk({9'h0, rx_overflow}, 10'h000);
    repeat (70) @(negedge clk_sys);
    chk({9'h0, rx_link_up}, 10'h000);
  endtask

  task automatic complete_run();
    $display("mismatches=%0d comparisons=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    resetn          = 1'b0;
    gmii_txd        = 8'h00;
    gmii_tx_en      = 1'b0;
    gmii_tx_er      = 1'b0;
    gmii_rx_ready   = 1'b1;
    rx_overflow_clr = 1'b0;
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
    tx_burst();
    rx_frame();
    rx_overflow_run();
    complete_run();
  end
endmodule // test_rfm_bridge

bind rfm_reduced_to_full_mii_bridge rfm_bridge_properties #(.RX_CLK_REGION(1'b1)) props (
  .clk_sys(clk_sys), .resetn(resetn), .gmii_tx_clk(gmii_tx_clk), .gmii_tx_en(gmii_tx_en), .rgmii_txd(rgmii_txd),
  .rgmii_tx_ctl(rgmii_tx_ctl), .rgmii_rx_clk(rgmii_rx_clk), .rgmii_rx_ctl(rgmii_rx_ctl),
  .gmii_rx_clk(gmii_rx_clk), .gmii_col(gmii_col), .gmii_crs(gmii_crs), .gmii_rx_clk_regional(gmii_rx_clk_regional),
  .gmii_rxd(gmii_rxd), .gmii_rx_stb(gmii_rx_stb), .gmii_rx_ready(gmii_rx_ready), .rx_in_ready(rx_in_ready),
  .rx_overflow(rx_overflow), .rx_overflow_clr(rx_overflow_clr), .rx_link_up(rx_link_up));

`default_nettype wire
